// File: src/oscsel_top.sv
// power-on oscillator source selection and configuration words
`default_nettype none
// Overview of operation
// - instruction clock is the selected system clock divided by two.
// - power-on source comes from the source field; later only permitted switches.
// - source codes 000 to 111 name the eight system clock sources.
// - erased configuration selects fast RC with divide-by-N postscaler.
// - primary mode 11 off, 10 high-speed, 01 medium crystal, 00 external clock.
// - outside crystal modes, pin bit chooses instruction clock output or general I/O.
// - switch mode 1x none, 01 switching only, 00 switching and fail-safe monitor.
// - two-speed bit starts on fast RC, then moves to chosen source when ready.
// - one-way bit allows a single pin reassignment, else repeated ones.
// - unimplemented configuration bits always read as one.
// - primary mode field matters only for source codes 010 and 011.
module oscsel_top
	import oscsel_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_ERASE,
	input wire logic I_PROG_WE,
	input wire logic I_PROG_WORD,
	input wire logic [15:0] I_PROG_DATA,
	input wire logic I_OSC_TICK,
	input wire logic I_SRC_READY,
	input wire logic I_SW_REQ,
	input wire logic [2:0] I_SW_NEW,
	input wire logic I_PPS_REQ,
	input wire logic I_GPIO_OUT,
	input wire logic I_GPIO_OE,
	input wire logic I_SECOND_OSC_PIN_IN,
	output logic [15:0] O_SRC_CFG,
	output logic [15:0] O_MODE_CFG,
	output logic [2:0] O_CUR_SRC,
	output logic [1:0] O_PRI_MODE,
	output logic O_SW_EN,
	output logic O_FAIL_SAFE_MONITOR_EN,
	output logic O_CY_TICK,
	output logic O_PPS_WE,
	output logic O_PPS_LOCKED,
	output logic O_SECOND_OSC_PIN_OUT,
	output logic O_SECOND_OSC_PIN_OE,
	output logic O_GPIO_IN
);
	logic [15:0] src_cfg_q, src_cfg_d, mode_cfg_q, mode_cfg_d;
	oscsel_state_e st_q, st_d;
	logic [2:0] cur_q, cur_d;
	logic pps_used_q, pps_used_d, pps_we_q, pps_we_d;
	logic pin_meta_q, pin_sync_q, gpio_in_q;
	logic [2:0] sel_src;
	logic [1:0] pri_mode, sw_mode;
	logic two_speed, one_way, clkout_fn, sw_en, xtal_pin, cy_level;

	// primary sources need a running primary oscillator
	function automatic logic src_permitted(input logic [2:0] s, input logic [1:0] m);
		src_permitted = !(((s == SRC_PRIMARY) || (s == SRC_PRIMARY_PLL)) && (m == PRI_DISABLED));
	endfunction

	// is the current source a primary one in crystal mode
	function automatic logic crystal_on(input logic [2:0] s, input logic [1:0] m);
		crystal_on = ((s == SRC_PRIMARY) || (s == SRC_PRIMARY_PLL))
			&& ((m == PRI_MEDIUM_XTAL) || (m == PRI_HIGH_XTAL));
	endfunction

	// programmer writes words
	// words survive I_RST, like nonvolatile cells; only an erase clears them
	always_comb begin
		src_cfg_d = src_cfg_q;
		mode_cfg_d = mode_cfg_q;
		if (I_ERASE) begin
			src_cfg_d = CFG_ERASED;
			mode_cfg_d = CFG_ERASED;
		end else if (I_PROG_WE && (I_PROG_WORD == PROG_SRC_WORD)) begin
			src_cfg_d = I_PROG_DATA | SRC_UNIMPL_MASK;
		end else if (I_PROG_WE && (I_PROG_WORD == PROG_MODE_WORD)) begin
			mode_cfg_d = I_PROG_DATA | MODE_UNIMPL_MASK;
		end
	end

	always_ff @(posedge I_MCLK) begin
		src_cfg_q <= src_cfg_d;
		mode_cfg_q <= mode_cfg_d;
	end

	// field decode from the stored words
	always_comb begin
		sel_src = src_cfg_q[SRC_SEL_LSB +: 3];
		two_speed = src_cfg_q[TWO_SPEED_BIT];
		pri_mode = mode_cfg_q[PRI_MODE_LSB +: 2];
		clkout_fn = mode_cfg_q[CLKOUT_FN_BIT];
		one_way = mode_cfg_q[PPS_ONE_WAY_BIT];
		sw_mode = mode_cfg_q[SW_MON_LSB +: 2];
		sw_en = (sw_mode == SWM_BOTH_ON) || (sw_mode == SWM_SWITCH_ONLY);
	end

	// source sequencing: power-on pick, optional two-speed hop, then switching
	always_comb begin
		st_d = st_q;
		cur_d = cur_q;
		case (st_q)
			ST_POR: begin
				if (two_speed && (sel_src != SRC_FAST_RC)) begin
					cur_d = SRC_FAST_RC;
					st_d = ST_TWO_SPEED;
				end else begin
					cur_d = sel_src;
					st_d = ST_RUN;
				end
			end
			ST_TWO_SPEED: begin
				if (I_SRC_READY) begin
					cur_d = sel_src;
					st_d = ST_RUN;
				end
			end
			default: begin
				if (I_SW_REQ && sw_en && src_permitted(I_SW_NEW, pri_mode)) begin
					cur_d = I_SW_NEW;
				end
			end
		endcase
	end

	// reset is the power-on event; the source fields are sampled just after it
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			st_q <= ST_POR;
			cur_q <= SRC_FAST_RC;
		end else begin
			st_q <= st_d;
			cur_q <= cur_d;
		end
	end

	always_comb begin
		pps_we_d = I_PPS_REQ && !(one_way && pps_used_q);
		pps_used_d = pps_used_q || pps_we_d;
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			pps_used_q <= 1'b0;
			pps_we_q <= 1'b0;
		end else begin
			pps_used_q <= pps_used_d;
			pps_we_q <= pps_we_d;
		end
	end

	// pin input crosses in from outside, three flops before use
	always_ff @(posedge I_MCLK) begin
		if (I_RST) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			gpio_in_q <= 1'b0;
		end else begin
			pin_meta_q <= I_SECOND_OSC_PIN_IN;
			pin_sync_q <= pin_meta_q;
			gpio_in_q <= pin_sync_q;
		end
	end

	oscsel_cy_div u_cy_div (
		.i_clk(I_MCLK),
		.i_rst(I_RST),
		.i_osc_tick(I_OSC_TICK),
		.o_cy_tick(O_CY_TICK),
		.o_cy_level(cy_level)
	);

	always_comb begin
		xtal_pin = crystal_on(cur_q, pri_mode);
		if (xtal_pin) begin
			O_SECOND_OSC_PIN_OUT = 1'b0;
			O_SECOND_OSC_PIN_OE = 1'b0;
		end else if (clkout_fn) begin
			O_SECOND_OSC_PIN_OUT = cy_level;
			O_SECOND_OSC_PIN_OE = 1'b1;
		end else begin
			O_SECOND_OSC_PIN_OUT = I_GPIO_OUT;
			O_SECOND_OSC_PIN_OE = I_GPIO_OE;
		end
	end

	assign O_CUR_SRC = cur_q;
	assign O_PRI_MODE = ((cur_q == SRC_PRIMARY) || (cur_q == SRC_PRIMARY_PLL)) ? pri_mode : PRI_DISABLED;
	assign O_SW_EN = sw_en;
	assign O_FAIL_SAFE_MONITOR_EN = (sw_mode == SWM_BOTH_ON);
	assign O_SRC_CFG = src_cfg_q;
	assign O_MODE_CFG = mode_cfg_q;
	assign O_PPS_WE = pps_we_q;
	assign O_PPS_LOCKED = one_way && pps_used_q;
	assign O_GPIO_IN = gpio_in_q;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	a_por_source_pick: assert property (st_q == ST_POR && !two_speed |=> cur_q == $past(sel_src))
		else $error("power-on source not taken from field");
	a_src_unimpl_ones: assert property ((O_SRC_CFG & SRC_UNIMPL_MASK) == SRC_UNIMPL_MASK)
		else $error("source word unimplemented bits not one");
	a_mode_unimpl_ones: assert property ((O_MODE_CFG & MODE_UNIMPL_MASK) == MODE_UNIMPL_MASK)
		else $error("mode word unimplemented bits not one");
	a_two_speed_start: assert property (st_q == ST_POR && two_speed && sel_src != SRC_FAST_RC
		|=> cur_q == SRC_FAST_RC && st_q == ST_TWO_SPEED)
		else $error("two-speed start not on fast RC");
	a_switch_blocked: assert property (st_q == ST_RUN && !sw_en |=> $stable(cur_q))
		else $error("source changed with switching off");
	a_fail_safe_monitor_policy: assert property (O_FAIL_SAFE_MONITOR_EN |-> O_SW_EN)
		else $error("monitor on without switching");
	a_pps_one_way: assert property (O_PPS_WE && one_way |=> !O_PPS_WE [*2])
		else $error("second pin reassignment allowed");
	a_clkout_drive: assert property (!xtal_pin && clkout_fn |-> O_SECOND_OSC_PIN_OE && O_SECOND_OSC_PIN_OUT == cy_level)
		else $error("clock output pin not driving instruction clock");
	a_cy_half_rate: assert property (O_CY_TICK |-> I_OSC_TICK && !$past(O_CY_TICK))
		else $error("instruction tick faster than half rate");
	a_mode_ignored: assert property (cur_q != SRC_PRIMARY && cur_q != SRC_PRIMARY_PLL
		|-> O_PRI_MODE == PRI_DISABLED)
		else $error("primary mode visible for non-primary source");
	a_erase_default: assert property (I_ERASE |=> O_SRC_CFG == CFG_ERASED && sel_src == SRC_FAST_RC_DIV_N)
		else $error("erase does not select divide-by-N");
endmodule // oscsel_top
`default_nettype wire

// File: src/oscsel_pkg.sv
// constants for the power-on oscillator source selection block
`default_nettype none
package oscsel_pkg;
	localparam int CFG_W = 16;
	// word select on the programming port
	localparam logic PROG_SRC_WORD = 1'b0;
	localparam logic PROG_MODE_WORD = 1'b1;
	// erased configuration reads all ones
	localparam logic [15:0] CFG_ERASED = 16'hFFFF;
	// unimplemented positions, forced to one
	localparam logic [15:0] SRC_UNIMPL_MASK = 16'hFF78;
	localparam logic [15:0] MODE_UNIMPL_MASK = 16'hFF18;
	// initial source word fields
	localparam int SRC_SEL_LSB = 0;
	localparam int TWO_SPEED_BIT = 7;
	// mode word fields
	localparam int PRI_MODE_LSB = 0;
	localparam int CLKOUT_FN_BIT = 2;
	localparam int PPS_ONE_WAY_BIT = 5;
	localparam int SW_MON_LSB = 6;
	// system clock sources
	localparam logic [2:0] SRC_FAST_RC = 3'h0;
	localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRIMARY = 3'h2;
	localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_FAST_RC_DIV_N = 3'h7;
	// primary oscillator modes
	localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
	localparam logic [1:0] PRI_MEDIUM_XTAL = 2'h1;
	localparam logic [1:0] PRI_HIGH_XTAL = 2'h2;
	localparam logic [1:0] PRI_DISABLED = 2'h3;
	// switching and monitor modes
	localparam logic [1:0] SWM_BOTH_ON = 2'h0;
	localparam logic [1:0] SWM_SWITCH_ONLY = 2'h1;
	// instruction clock ratio
	localparam int CY_DIV = 2;
	typedef enum logic [1:0] {ST_POR, ST_TWO_SPEED, ST_RUN} oscsel_state_e;
endpackage : oscsel_pkg
`default_nettype wire

// File: src/oscsel_cy_div.sv
// instruction clock enable divider
`default_nettype none
module oscsel_cy_div
	import oscsel_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_osc_tick,
	output logic o_cy_tick,
	output logic o_cy_level
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic lvl_q;
	logic lvl_d;
	logic wrap;

	// count source ticks, wrap every CY_DIV of them
	always_comb begin
		wrap = i_osc_tick && (cnt_q == 2'(CY_DIV - 1));
		cnt_d = cnt_q;
		lvl_d = lvl_q;
		if (i_osc_tick) begin
			cnt_d = wrap ? 2'h0 : 2'(cnt_q + 2'h1);
			lvl_d = ~lvl_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= 2'h0;
			lvl_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign o_cy_tick = wrap;
	assign o_cy_level = lvl_q;
endmodule // oscsel_cy_div
`default_nettype wire

// File: bench/oscsel_src_model.sv
// far-side model: selected clock source ticks and its ready flag
`default_nettype none
module oscsel_src_model #(
	parameter int TICK_DIV = 3,
	parameter int READY_DLY = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	output logic o_tick,
	output logic o_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int div_q;
	int dly_q;
	// the source ticks slower than the master clock, one-cycle pulses
	always @(posedge i_clk) begin
		if (i_rst) begin
			div_q <= 0;
			o_tick <= 1'b0;
		end else begin
			div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
			o_tick <= (div_q == TICK_DIV - 1);
		end
	end
	// slow start-up ready
	// ready comes late, like a crystal, so the two-speed wait is visible
	always @(posedge i_clk) begin
		if (i_rst) begin
			dly_q <= 0;
			o_ready <= 1'b0;
		end else if (dly_q < READY_DLY) begin
			dly_q <= dly_q + 1;
		end else begin
			o_ready <= 1'b1;
		end
	end
endmodule // oscsel_src_model
`default_nettype wire

// File: bench/oscsel_top_tb.sv
// self-checking bench for the oscillator source selection block
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
	$display("Error %s expected %0h seen %0h", what, exp, got); end end
module oscsel_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_MCLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_ERASE = 1'b1;
	logic I_PROG_WE = 1'b0;
	logic I_PROG_WORD = 1'b0;
	logic [15:0] I_PROG_DATA = 16'h0000;
	logic I_SW_REQ = 1'b0;
	logic [2:0] I_SW_NEW = 3'h0;
	logic I_PPS_REQ = 1'b0;
	logic I_GPIO_OUT = 1'b0;
	logic I_GPIO_OE = 1'b0;
	wire logic osc_tick, src_ready, second_osc_pin_pin;
	logic [15:0] O_SRC_CFG, O_MODE_CFG;
	logic [2:0] O_CUR_SRC, exp_cur;
	logic [1:0] O_PRI_MODE;
	logic O_SW_EN, O_FAIL_SAFE_MONITOR_EN, O_CY_TICK, O_PPS_WE, O_PPS_LOCKED, O_SECOND_OSC_PIN_OUT, O_SECOND_OSC_PIN_OE, O_GPIO_IN;
	int failures = 0;
	int check_count = 0;
	int osc_n, cy_n;
	logic cy_lvl;
	// pin has a pull-up, so a released pin reads one
	assign second_osc_pin_pin = O_SECOND_OSC_PIN_OE ? O_SECOND_OSC_PIN_OUT : 1'b1;
	always #5 I_MCLK = ~I_MCLK;
	oscsel_src_model SRC (.i_clk(I_MCLK), .i_rst(I_RST), .o_tick(osc_tick), .o_ready(src_ready));
	oscsel_top DUT (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ERASE(I_ERASE), .I_PROG_WE(I_PROG_WE),
		.I_PROG_WORD(I_PROG_WORD), .I_PROG_DATA(I_PROG_DATA), .I_OSC_TICK(osc_tick), .I_SRC_READY(src_ready),
		.I_SW_REQ(I_SW_REQ), .I_SW_NEW(I_SW_NEW), .I_PPS_REQ(I_PPS_REQ), .I_GPIO_OUT(I_GPIO_OUT),
		.I_GPIO_OE(I_GPIO_OE), .I_SECOND_OSC_PIN_IN(second_osc_pin_pin), .O_SRC_CFG(O_SRC_CFG), .O_MODE_CFG(O_MODE_CFG),
		.O_CUR_SRC(O_CUR_SRC), .O_PRI_MODE(O_PRI_MODE), .O_SW_EN(O_SW_EN), .O_FAIL_SAFE_MONITOR_EN(O_FAIL_SAFE_MONITOR_EN),
		.O_CY_TICK(O_CY_TICK), .O_PPS_WE(O_PPS_WE), .O_PPS_LOCKED(O_PPS_LOCKED), .O_SECOND_OSC_PIN_OUT(O_SECOND_OSC_PIN_OUT),
		.O_SECOND_OSC_PIN_OE(O_SECOND_OSC_PIN_OE), .O_GPIO_IN(O_GPIO_IN));
	// count source ticks and instruction ticks since reset
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			osc_n <= 0;
			cy_n <= 0;
			cy_lvl <= 1'b0;
		end else begin
			// instruction clock level flips on every source tick, giving half the rate
			cy_lvl <= cy_lvl ^ (osc_tick === 1'b1);
			osc_n <= osc_n + int'(osc_tick);
			cy_n <= cy_n + int'(O_CY_TICK === 1'b1);
		end
	end
	task automatic end_of_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic prog(input logic w, input logic [15:0] d);
		@(negedge I_MCLK);
		I_PROG_WORD = w;
		I_PROG_DATA = d;
		I_PROG_WE = 1'b1;
		@(negedge I_MCLK);
		I_PROG_WE = 1'b0;
		@(negedge I_MCLK);
	endtask
	// power-on reset, then a few cycles to settle
	task automatic por();
		I_RST = 1'b1;
		repeat (2) @(negedge I_MCLK);
		I_RST = 1'b0;
		repeat (3) @(negedge I_MCLK);
	endtask
	task automatic pulse_req(input logic pps, input logic [2:0] n);
		I_PPS_REQ = pps;
		I_SW_REQ = ~pps;
		I_SW_NEW = n;
		@(negedge I_MCLK);
		I_PPS_REQ = 1'b0;
		I_SW_REQ = 1'b0;
	endtask
	// hang guard: the sequence needs a few hundred cycles at most
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (20) @(negedge I_MCLK);
		I_ERASE = 1'b0;
		I_RST = 1'b0;
		repeat (3) @(negedge I_MCLK);
		`CHK("erased_src", 16'hFFFF, O_SRC_CFG)
		`CHK("erased_mode", 16'hFFFF, O_MODE_CFG)
		// erased words carry the two-speed bit, so fast RC runs until the source is ready
		`CHK("erased_early", 3'h0, O_CUR_SRC)
		repeat (12) @(negedge I_MCLK);
		`CHK("erased_cur", 3'h7, O_CUR_SRC)
		for (int c = 0; c < 8; c++) begin
			prog(1'b0, {8'h00, 1'b0, 4'h0, 3'(c)});
			por();
			`CHK("src_cfg", {8'hFF, 1'b0, 4'hF, 3'(c)}, O_SRC_CFG)
			`CHK("cur_src", 3'(c), O_CUR_SRC)
		end
		// two-speed start holds fast RC until the source is ready
		prog(1'b0, 16'h0084);
		por();
		`CHK("two_speed_early", 3'h0, O_CUR_SRC)
		repeat (12) @(negedge I_MCLK);
		`CHK("two_speed_late", 3'h4, O_CUR_SRC)
		prog(1'b0, 16'h0002);
		por();
		for (int m = 0; m < 4; m++) begin
			prog(1'b1, {8'h00, 2'b11, 1'b0, 2'b00, 1'b1, 2'(m)});
			`CHK("mode_cfg", {8'hFF, 2'b11, 1'b0, 2'b11, 1'b1, 2'(m)}, O_MODE_CFG)
			`CHK("pri_mode", 2'(m), O_PRI_MODE)
			`CHK("second_osc_pin_oe", (m == 1 || m == 2) ? 1'b0 : 1'b1, O_SECOND_OSC_PIN_OE)
			`CHK("second_osc_pin_out", (m == 1 || m == 2) ? 1'b0 : cy_lvl, O_SECOND_OSC_PIN_OUT)
		end
		// a medium crystal setting must stay hidden while a non-primary source runs
		prog(1'b1, 16'h00C5);
		prog(1'b0, 16'h0000);
		por();
		`CHK("pri_ignored", 2'h3, O_PRI_MODE)
		`CHK("second_osc_pin_oe_nonpri", 1'b1, O_SECOND_OSC_PIN_OE)
		exp_cur = 3'h0;
		for (int f = 0; f < 4; f++) begin
			prog(1'b1, {8'h00, 2'(f), 1'b0, 2'b00, 1'b1, 2'b11});
			`CHK("sw_en", ~f[1], O_SW_EN)
			`CHK("fail_safe_monitor_en", f == 0, O_FAIL_SAFE_MONITOR_EN)
			pulse_req(1'b0, 3'(f + 4));
			@(negedge I_MCLK);
			if (f < 2) exp_cur = 3'(f + 4);
			`CHK("switched", exp_cur, O_CUR_SRC)
		end
		for (int ow = 0; ow < 2; ow++) begin
			prog(1'b1, {8'h00, 2'b11, 1'(ow), 2'b00, 1'b1, 2'b11});
			por();
			pulse_req(1'b1, 3'h0);
			`CHK("pps_first", 1'b1, O_PPS_WE)
			@(negedge I_MCLK);
			pulse_req(1'b1, 3'h0);
			`CHK("pps_again", ow == 0, O_PPS_WE)
			`CHK("pps_locked", 1'(ow), O_PPS_LOCKED)
		end
		// general I/O on the second pin, both directions through the pull-up
		prog(1'b1, 16'h00C3);
		I_GPIO_OUT = 1'b1;
		I_GPIO_OE = 1'b1;
		repeat (4) @(negedge I_MCLK);
		`CHK("gpio_oe", 1'b1, O_SECOND_OSC_PIN_OE)
		`CHK("gpio_out_high", 1'b1, O_SECOND_OSC_PIN_OUT)
		`CHK("gpio_in_driven", 1'b1, O_GPIO_IN)
		I_GPIO_OUT = 1'b0;
		repeat (4) @(negedge I_MCLK);
		`CHK("gpio_out_low", 1'b0, O_SECOND_OSC_PIN_OUT)
		`CHK("gpio_in_low", 1'b0, O_GPIO_IN)
		I_GPIO_OE = 1'b0;
		repeat (4) @(negedge I_MCLK);
		`CHK("gpio_released", 1'b0, O_SECOND_OSC_PIN_OE)
		`CHK("gpio_in_high", 1'b1, O_GPIO_IN)
		// a late erase brings back the unprogrammed power-on choice
		I_ERASE = 1'b1;
		@(negedge I_MCLK);
		I_ERASE = 1'b0;
		`CHK("erase_src", 16'hFFFF, O_SRC_CFG)
		`CHK("erase_mode", 16'hFFFF, O_MODE_CFG)
		por();
		repeat (12) @(negedge I_MCLK);
		`CHK("erase_cur", 3'h7, O_CUR_SRC)
		`CHK("cy_ticks", osc_n / 2, cy_n)
		end_of_test();
	end
endmodule // oscsel_top_tb
`default_nettype wire
